// *** inc/bid_pkg.sv ***
// Package of constants and carrier types for the board I/O decoder block.
package bid_pkg;

    // Decoded I/O windows; each is 1 KB, matched on address bits 15:10.
    localparam logic [5:0] BID_WIN_WDOG_KICK = 6'h10; // 4000-43FF
    localparam logic [5:0] BID_WIN_WDOG_ALT = 6'h18;  // 6000-63FF
    localparam logic [5:0] BID_WIN_RTC = 6'h20;       // 8000-83FF
    localparam logic [5:0] BID_WIN_PAR = 6'h34;       // D000-D3FF

    // Recommended software addresses, kept for reference.
    localparam logic [15:0] BID_PREF_KICK = 16'h4210;
    localparam logic [15:0] BID_PREF_AUTO = 16'h4211;
    localparam logic [15:0] BID_PREF_ALT = 16'h6210;
    localparam logic [15:0] BID_PREF_RTC = 16'h8210;
    localparam logic [15:0] BID_PREF_PAR = 16'hd210;

    // Parallel unit offsets, compared on the low four address bits.
    localparam logic [3:0] BID_OFS_DATA_FIRST = 4'h0;
    localparam logic [3:0] BID_OFS_DATA_SECOND = 4'h1;
    localparam logic [3:0] BID_OFS_DATA_THIRD = 4'h2;
    localparam logic [3:0] BID_OFS_FIRST_SET_OUT = 4'h3;
    localparam logic [3:0] BID_OFS_FIRST_SET_IN = 4'h4;
    localparam logic [3:0] BID_OFS_SECOND_SET_OUT = 4'h5;
    localparam logic [3:0] BID_OFS_SECOND_SET_IN = 4'h6;
    localparam logic [3:0] BID_OFS_THIRD_SET_OUT = 4'h7;
    localparam logic [3:0] BID_OFS_THIRD_SET_IN = 4'h8;

    // Reset values.
    localparam logic [7:0] BID_RST_DATA = 8'h00;
    localparam logic BID_RST_AUTO_WDOG = 1'b1;
    localparam logic [7:0] BID_RST_READ = 8'h00;

    // Number of parallel ports.
    localparam int BID_NPORTS = 3;

    // One host I/O request as sampled on a clock edge.
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } bid_io_req_t;

    // Pins of one 8-bit parallel port.
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } bid_port_drv_t;

endpackage

// *** hw/bid_top.sv ***
// Board I/O address decoder with a three-port parallel I/O unit.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Odd 4000-43FF access lights LED only; mode unchanged.
// - Auto watchdog on at boot; off latches.
// - Access 6000-63FF also kicks watchdog, LED on.
// - 8000-83FF accesses assert real-time clock select.
// - D000-D3FF accesses select the parallel unit.
// - Offsets 0-2 are port data registers.
// - Offsets 3/4 set port A out/in.
// - Offsets 5/6 set port B out/in.
// - Offsets 7/8 set port C out/in.
// - Unclaimed addresses stay unselected for expansion.
// - First expansion interrupt drives IRQ5.
// - Second expansion interrupt drives IRQ9.
// - Port drivers high impedance after reset.
module bid_top (
    input wire logic core_clk_in, // Host I/O bus clock.
    input wire logic sys_rst_in, // Board reset, active high.
    input wire bid_pkg::bid_io_req_t io_req_in, // Host I/O cycle.
    input wire logic auto_wdog_off_in, // Pulse: software turns auto off.
    input wire logic [1:0] exp_irq_in, // Expansion-bus interrupts.
    input wire logic [7:0] first_port_pin_in, // Port A pin levels.
    input wire logic [7:0] second_port_pin_in, // Port B pin levels.
    input wire logic [7:0] third_port_pin_in, // Port C pin levels.
    output logic [7:0] io_rdata_out, // Read data for the host.
    output logic io_claim_out, // This board answers the cycle.
    output logic watchdog_retrigger_input_out, // Kick pulse.
    output logic auto_wdog_out, // Automatic watchdog mode.
    output logic led_out, // Status LED on.
    output logic rtc_cs_out, // Real-time clock chip select.
    output logic irq5_out, // Host IRQ5.
    output logic irq9_out, // Host IRQ9.
    output logic [7:0] first_port_pin_out, // Port A drive value.
    output logic [7:0] first_port_pin_oe_out, // Port A enable.
    output logic [7:0] second_port_pin_out, // Port B drive value.
    output logic [7:0] second_port_pin_oe_out, // Port B enable.
    output logic [7:0] third_port_pin_out, // Port C drive value.
    output logic [7:0] third_port_pin_oe_out // Port C enable.
);
    import bid_pkg::*;

    // Timing in brief: a request is taken on the rising edge at which rd
    // or wr is high. Claim, kick, clock select and read data follow one
    // cycle later. Pin drive, pin enable, LED and mode follow two cycles
    // later, because each top-level output is copied from its own flop.
    // The host may issue requests back to back; every strobe is a fresh
    // one-cycle pulse per request and nothing is queued.

    ////////////////////////////////////////////////////////////////////////
    // Address decode.

    // Any access, read or write.
    wire logic acc = io_req_in.rd | io_req_in.wr;
    // Upper six address bits pick a 1 KB window.
    wire logic [5:0] win = io_req_in.addr[15:10];
    wire logic hit_kick = (win == BID_WIN_WDOG_KICK);
    wire logic hit_alt = (win == BID_WIN_WDOG_ALT);
    wire logic hit_rtc = (win == BID_WIN_RTC);
    wire logic hit_par = (win == BID_WIN_PAR);
    // Even access in the first window kicks the watchdog.
    wire logic kick_even = acc & hit_kick & ~io_req_in.addr[0];
    // Odd access only lights the LED; it neither kicks nor changes the mode.
    wire logic auto_sel = acc & hit_kick & io_req_in.addr[0];
    // Second watchdog window kicks on any address.
    wire logic kick_alt = acc & hit_alt;
    wire logic kick = kick_even | kick_alt;
    wire logic rtc_sel = acc & hit_rtc;
    wire logic par_sel = acc & hit_par;
    // Only these windows are claimed; all else is left to expansion.
    // Gaps between windows stay silent so stacked boards may answer.
    wire logic claim =
        acc & (hit_kick | hit_alt | hit_rtc | hit_par);
    // Offset within the parallel window, low bits only.
    wire logic [3:0] ofs = io_req_in.addr[3:0];
    wire logic par_wr = par_sel & io_req_in.wr;
    wire logic par_rd = par_sel & io_req_in.rd;

    ////////////////////////////////////////////////////////////////////////
    // Parallel ports, one generate pass per port.

    // Per-port data and direction state.
    logic [7:0] data_r [BID_NPORTS];
    logic [BID_NPORTS-1:0] dir_out_r;
    // Pin levels read back, indexed by port.
    wire logic [7:0] pin_lvl [BID_NPORTS];
    assign pin_lvl[0] = first_port_pin_in;
    assign pin_lvl[1] = second_port_pin_in;
    assign pin_lvl[2] = third_port_pin_in;

    genvar g;
    generate
        for (g = 0; g < BID_NPORTS; g++) begin : g_port
            // Offsets of this port's data and direction strobes.
            localparam logic [3:0] OFS_D = 4'(g);
            localparam logic [3:0] OFS_SO = 4'(3 + 2 * g);
            localparam logic [3:0] OFS_SI = 4'(4 + 2 * g);
            wire logic wr_d = par_wr & (ofs == OFS_D);
            // Written data is ignored on direction strobes.
            // Set-output strobe for this port.
            wire logic set_o =
                par_wr & (ofs == OFS_SO);
            // Set-input strobe for this port.
            wire logic set_i =
                par_wr & (ofs == OFS_SI);

            // Data latch holds the value driven when the port is output.
            always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    data_r[g] <= BID_RST_DATA;
                end else if (wr_d) begin
                    data_r[g] <= io_req_in.wdata;
                end
            end

            // Direction flag; reset leaves the drivers off.
            always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    dir_out_r[g] <= 1'b0;
                end else if (set_o) begin
                    dir_out_r[g] <= 1'b1;
                end else if (set_i) begin
                    dir_out_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Reads return what stands on the pins, not the data latch, so a port
    // set to input shows the outside level while one set to output shows
    // our own drive. Direction strobes are write-only and read as zero,
    // as do the unused offsets above the last strobe.
    // Read mux: data offsets return the pin levels; others read zero.
    wire logic [7:0] par_rdata =
        (ofs == BID_OFS_DATA_FIRST) ? pin_lvl[0] :
        (ofs == BID_OFS_DATA_SECOND) ? pin_lvl[1] :
        (ofs == BID_OFS_DATA_THIRD) ? pin_lvl[2] : BID_RST_READ;

    ////////////////////////////////////////////////////////////////////////
    // Watchdog mode, LED and decode outputs.

    // Auto mode is on from reset; once off it stays off until reset.
    logic auto_r;
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            auto_r <= BID_RST_AUTO_WDOG;
        end else if (auto_wdog_off_in) begin
            auto_r <= 1'b0;
        end
    end

    // LED latches on at any watchdog-window access.
    logic led_r;
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            led_r <= 1'b0;
        end else if (kick | auto_sel) begin
            led_r <= 1'b1;
        end
    end

    // All host-facing strobes are registered so the pins never glitch
    // while the address settles. The cost is one cycle of latency, which
    // the host sees as a fixed answer time. Interrupt lines pass through
    // one flop as well, purely to keep every output on a flop.
    // Registered strobes and read data, one cycle after the request.
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            watchdog_retrigger_input_out <= 1'b0;
            rtc_cs_out <= 1'b0;
            io_claim_out <= 1'b0;
            io_rdata_out <= BID_RST_READ;
            irq5_out <= 1'b0;
            irq9_out <= 1'b0;
        end else begin
            watchdog_retrigger_input_out <= kick;
            rtc_cs_out <= rtc_sel;
            io_claim_out <= claim;
            io_rdata_out <= par_rd ? par_rdata : BID_RST_READ;
            irq5_out <= exp_irq_in[0];
            irq9_out <= exp_irq_in[1];
        end
    end

    // Mode, LED and pin outputs copied out of their own flip-flops.
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            auto_wdog_out <= BID_RST_AUTO_WDOG;
            led_out <= 1'b0;
            first_port_pin_out <= BID_RST_DATA;
            second_port_pin_out <= BID_RST_DATA;
            third_port_pin_out <= BID_RST_DATA;
            first_port_pin_oe_out <= 8'h00;
            second_port_pin_oe_out <= 8'h00;
            third_port_pin_oe_out <= 8'h00;
        end else begin
            auto_wdog_out <= auto_r;
            led_out <= led_r;
            first_port_pin_out <= data_r[0];
            second_port_pin_out <= data_r[1];
            third_port_pin_out <= data_r[2];
            first_port_pin_oe_out <= {8{dir_out_r[0]}};
            second_port_pin_oe_out <= {8{dir_out_r[1]}};
            third_port_pin_oe_out <= {8{dir_out_r[2]}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks. Those tied to a request watch what this block drives one or two cycles
    // later; the high-offset check watches internal flops one cycle later.

    // An even access in the first window gives a kick pulse.
    chk_kick_pulse: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) kick_even |=> watchdog_retrigger_input_out)
        else $error("Even watchdog access did not kick.");

    // No kick pulse appears without a kicking access.
    chk_kick_only: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) !kick |=> !watchdog_retrigger_input_out)
        else $error("Kick pulse without an access.");

    // Once lit, the LED stays lit until reset.
    chk_led_stays: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) led_out |=> led_out)
        else $error("LED went dark without reset.");

    // An odd access lights the LED but gives no kick.
    chk_odd_no_kick: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        auto_sel && !kick |=> !watchdog_retrigger_input_out ##1 led_out)
        else $error("Odd access kicked or left LED off.");

    // The odd access lights the LED two cycles later.
    chk_odd_led_on: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) auto_sel |=> ##1 led_out)
        else $error("Odd access left LED off.");

    // Automatic mode, once off, never returns before reset.
    chk_auto_latch: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) !auto_r |=> !auto_r)
        else $error("Automatic watchdog came back on.");

    // Any access in the second window kicks.
    chk_alt_kick: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) kick_alt |=> watchdog_retrigger_input_out)
        else $error("Second window did not kick.");

    // The second window lights the LED as well.
    chk_alt_led: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) kick_alt |=> ##1 led_out)
        else $error("Second window left LED off.");

    // Clock window gives its select and a claim.
    chk_rtc_select: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) rtc_sel |=> rtc_cs_out && io_claim_out)
        else $error("Clock select missing.");

    // Parallel window is claimed.
    chk_par_claim: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) par_sel |=> io_claim_out)
        else $error("Parallel window not claimed.");

    // Port A turns to output on its set-output strobe.
    chk_par_dir: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        par_wr && ofs == BID_OFS_FIRST_SET_OUT
        |=> ##1 first_port_pin_oe_out == 8'hff)
        else $error("Port A did not turn to output.");

    // Port A turns to input on its set-input strobe.
    chk_first_dir_in: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        par_wr && ofs == BID_OFS_FIRST_SET_IN
        |=> ##1 first_port_pin_oe_out == 8'h00)
        else $error("Port A did not turn to input.");

    // Port B turns to output on its set-output strobe.
    chk_second_dir_out: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        par_wr && ofs == BID_OFS_SECOND_SET_OUT
        |=> ##1 second_port_pin_oe_out == 8'hff)
        else $error("Port B did not turn to output.");

    // Port B turns to input on its set-input strobe.
    chk_second_dir_in: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        par_wr && ofs == BID_OFS_SECOND_SET_IN
        |=> ##1 second_port_pin_oe_out == 8'h00)
        else $error("Port B did not turn to input.");

    // Port C turns to output on its set-output strobe.
    chk_third_dir_out: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        par_wr && ofs == BID_OFS_THIRD_SET_OUT
        |=> ##1 third_port_pin_oe_out == 8'hff)
        else $error("Port C did not turn to output.");

    // Port C turns to input on its set-input strobe.
    chk_third_dir_in: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        par_wr && ofs == BID_OFS_THIRD_SET_IN
        |=> ##1 third_port_pin_oe_out == 8'h00)
        else $error("Port C did not turn to input.");

    // Port B drives what was written to its data offset.
    chk_par_data: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        par_wr && ofs == BID_OFS_DATA_SECOND
        |=> ##1 second_port_pin_out == $past(io_req_in.wdata, 2))
        else $error("Port B data not driven.");

    // Port A drives what was written to its data offset.
    chk_first_data: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        par_wr && ofs == BID_OFS_DATA_FIRST
        |=> ##1 first_port_pin_out == $past(io_req_in.wdata, 2))
        else $error("Port A data not driven.");

    // Read data is zero for anything but a parallel read.
    chk_rd_idle_zero: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) !par_rd |=> io_rdata_out == BID_RST_READ)
        else $error("Read data without a parallel read.");

    // Unclaimed addresses stay unselected.
    chk_unclaimed: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        acc && !(hit_kick || hit_alt || hit_rtc || hit_par) |=> !io_claim_out)
        else $error("Unclaimed address was selected.");

    // Both interrupt lines follow their inputs one cycle late.
    chk_irq_route: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        ##1 (irq5_out == $past(exp_irq_in[0]))
        && (irq9_out == $past(exp_irq_in[1])))
        else $error("Interrupt routing wrong.");

    // The second line on its own.
    chk_irq9_route: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in) 1'b1 |=> irq9_out == $past(exp_irq_in[1]))
        else $error("Second interrupt routing wrong.");

    // While reset is held, no port drives its pins.
    chk_reset_drv_off: assert property (@(posedge core_clk_in)
        sys_rst_in && $past(sys_rst_in) |-> first_port_pin_oe_out == 8'h00
        && second_port_pin_oe_out == 8'h00 && third_port_pin_oe_out == 8'h00)
        else $error("Port drivers enabled in reset.");

    // Writes to offsets above the last strobe leave all directions and port A data unchanged.
    chk_ignore_high: assert property (@(posedge core_clk_in)
        disable iff (sys_rst_in)
        par_wr && ofs > BID_OFS_THIRD_SET_IN
        |=> dir_out_r == $past(dir_out_r) && data_r[0] == $past(data_r[0]))
        else $error("High offset write changed a port.");

endmodule
`default_nettype wire

// *** verif/bid_host_model.sv ***
// Host processor model issuing single I/O cycles to the decoder.
`timescale 1ns/1ps
`default_nettype none
module bid_host_model (
    input wire logic clk_in, // Host bus clock.
    output var bid_pkg::bid_io_req_t req_out // Request to the decoder.
);
    import bid_pkg::*;

    // The bus is idle from time zero.
    initial begin
        req_out = '0;
    end

    // Present one request just after an edge and hold it through the
    // sampling edge, then idle and let the registered answers land.
    task automatic io(input logic [15:0] a, input logic [7:0] d,
                      input logic r, input logic w);
        @(posedge clk_in);
        req_out <= '{addr: a, wdata: d, rd: r, wr: w};
        @(posedge clk_in);
        req_out <= '0;
        #1;
    endtask
endmodule
`default_nettype wire

// *** verif/bid_top_bench.sv ***
// Self-checking bench for the board I/O decoder and parallel unit.
`timescale 1ns/1ps
`default_nettype none
module bid_top_bench;
    import bid_pkg::*;

    // One table row: a request beside the strobes and data it should give.
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wd;
        logic rd;
        logic wr;
        logic [2:0] exp; // Claim, kick and clock select.
        logic [7:0] rdata;
    } bid_row_t;

    // Levels that the outside world puts on pins we do not drive.
    localparam logic [7:0] EXT [3] = '{8'h3c, 8'h5a, 8'h96};
    logic core_clk_in, sys_rst_in, auto_wdog_off_in;
    logic [1:0] exp_irq_in;
    bid_io_req_t io_req;
    logic [7:0] rdata;
    logic claim, kick, auto, led, rtc, irq5, irq9;
    logic [7:0] drv [3];
    logic [7:0] oe [3];
    logic [7:0] pin [3];
    int miscompares = 0;
    int check_count = 0;
    bid_row_t rows [16] = '{
        '{16'h4210, 8'h11, 1'b0, 1'b1, 3'b110, 8'h00},
        '{16'h4211, 8'h00, 1'b1, 1'b0, 3'b100, 8'h00},
        '{16'h43fe, 8'h00, 1'b1, 1'b0, 3'b110, 8'h00},
        '{16'h6210, 8'h22, 1'b0, 1'b1, 3'b110, 8'h00},
        '{16'h63ff, 8'h00, 1'b1, 1'b0, 3'b110, 8'h00},
        '{16'h8210, 8'h00, 1'b1, 1'b0, 3'b101, 8'h00},
        '{16'h83ff, 8'h33, 1'b0, 1'b1, 3'b101, 8'h00},
        '{16'hd210, 8'h00, 1'b1, 1'b0, 3'b100, 8'h3c},
        '{16'hd211, 8'h00, 1'b1, 1'b0, 3'b100, 8'h5a},
        '{16'hd212, 8'h00, 1'b1, 1'b0, 3'b100, 8'h96},
        '{16'hd219, 8'h00, 1'b1, 1'b0, 3'b100, 8'h00},
        '{16'hd214, 8'h00, 1'b1, 1'b0, 3'b100, 8'h00},
        '{16'h2000, 8'h00, 1'b1, 1'b0, 3'b000, 8'h00},
        '{16'h03f8, 8'h00, 1'b1, 1'b0, 3'b000, 8'h00},
        '{16'hf000, 8'h00, 1'b1, 1'b0, 3'b000, 8'h00},
        '{16'h4400, 8'h00, 1'b1, 1'b0, 3'b000, 8'h00}};

    // Each pin shows our drive where enabled, else the outside level.
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            pin[k] = (drv[k] & oe[k]) | (EXT[k] & ~oe[k]);
        end
    end

    bid_host_model host (.clk_in(core_clk_in), .req_out(io_req));

    bid_top dut (
        .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .io_req_in(io_req), .auto_wdog_off_in(auto_wdog_off_in),
        .exp_irq_in(exp_irq_in), .first_port_pin_in(pin[0]),
        .second_port_pin_in(pin[1]), .third_port_pin_in(pin[2]),
        .io_rdata_out(rdata), .io_claim_out(claim),
        .watchdog_retrigger_input_out(kick), .auto_wdog_out(auto),
        .led_out(led), .rtc_cs_out(rtc), .irq5_out(irq5),
        .irq9_out(irq9), .first_port_pin_out(drv[0]),
        .first_port_pin_oe_out(oe[0]), .second_port_pin_out(drv[1]),
        .second_port_pin_oe_out(oe[1]), .third_port_pin_out(drv[2]),
        .third_port_pin_oe_out(oe[2]));

    // Compares a byte result and counts it.
    task automatic cmp8(input logic [7:0] got, input logic [7:0] want);
        check_count++;
        if (got !== want) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    // Compares a single-bit result.
    task automatic cmp1(input logic got, input logic want);
        cmp8({7'h00, got}, {7'h00, want});
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Free-running 100 MHz clock.
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    // Cuts a hang short; the whole run needs under a hundred cycles.
    initial begin
        #200000;
        miscompares++;
        summarize();
    end

    // Main sequence: reset, table, then the hand-written cases.
    initial begin
        sys_rst_in = 1'b1;
        auto_wdog_off_in = 1'b0;
        exp_irq_in = 2'b00;
        repeat (10) @(posedge core_clk_in);
        #1;
        cmp1(auto, 1'b1);
        cmp1(led, 1'b0);
        for (int k = 0; k < 3; k++) cmp8(oe[k], 8'h00);
        @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        foreach (rows[i]) begin
            host.io(rows[i].addr, rows[i].wd, rows[i].rd, rows[i].wr);
            cmp1(claim, rows[i].exp[2]);
            cmp1(kick, rows[i].exp[1]);
            cmp1(rtc, rows[i].exp[0]);
            cmp8(rdata, rows[i].rdata);
        end
        cmp1(led, 1'b1);
        // Each port: set output through an alias, write, read, set input.
        for (int k = 0; k < 3; k++) begin
            host.io(16'hd313 + 16'(2 * k), 8'h00, 1'b0, 1'b1);
            host.io(16'hd210 + 16'(k), 8'hc3 ^ 8'(k), 1'b0, 1'b1);
            @(posedge core_clk_in);
            #1;
            cmp8(oe[k], 8'hff);
            cmp8(drv[k], 8'hc3 ^ 8'(k));
            host.io(16'hd210 + 16'(k), 8'h00, 1'b1, 1'b0);
            cmp8(rdata, 8'hc3 ^ 8'(k));
            host.io(16'hd219, 8'hff, 1'b0, 1'b1);
            host.io(16'hd214 + 16'(2 * k), 8'h00, 1'b0, 1'b1);
            @(posedge core_clk_in);
            #1;
            cmp8(oe[k], 8'h00);
            cmp8(drv[k], 8'hc3 ^ 8'(k));
        end
        // Turning automatic mode off latches against a later odd access.
        @(posedge core_clk_in);
        auto_wdog_off_in <= 1'b1;
        @(posedge core_clk_in);
        auto_wdog_off_in <= 1'b0;
        host.io(16'h4211, 8'h00, 1'b0, 1'b1);
        @(posedge core_clk_in);
        #1;
        cmp1(auto, 1'b0);
        // Each expansion interrupt reaches its own host line.
        for (int k = 1; k < 3; k++) begin
            @(posedge core_clk_in);
            exp_irq_in <= 2'(k);
            @(posedge core_clk_in);
            #1;
            cmp1(irq5, k[0]);
            cmp1(irq9, k[1]);
        end
        // A second reset restores automatic mode and darkens the LED;
        // port C is driving beforehand so that reset must switch it off.
        host.io(16'hd217, 8'h00, 1'b0, 1'b1);
        @(posedge core_clk_in);
        sys_rst_in <= 1'b1;
        @(posedge core_clk_in);
        #1;
        cmp1(auto, 1'b1);
        cmp1(led, 1'b0);
        cmp8(oe[2], 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
